// ---- rtl/fis_pkg.sv ----
// Purpose: Shared constants and word types of the FIS transaction port.
// Assumes: Host side runs on clk_i, link side on the link clock.
// Notes:   All names are used as fis_pkg::name; nothing is imported.
// Behaviour
// - Raise link-up on the interface clock once the link is up.
// - Transmit destination-ready is low while words can be accepted.
// - Up to four transmit words after not-ready are still taken.
// - A host transmit abort sends SYNC to the link.
// - SYNC during a write pulses transmit destination-abort one cycle.
// - Receive words carry start-of-frame first and end-of-frame last.
// - Receive source-ready is low only with a valid receive word.
// - Receive source-ready drops within four cycles of host not-ready.
// - SYNC during a read pulses receive source-abort one cycle.
// - A host receive abort sends SYNC to the link.
package fis_pkg;

	// ------------------------------------------------------------------
	// Sizes and counts
	// ------------------------------------------------------------------
	localparam int unsigned WORD_W     = 32;
	localparam int unsigned SKID_DEPTH = 8;
	localparam int unsigned PTR_W      = 3;
	localparam int unsigned CNT_W      = 4;
	// Words the host may still push after destination-ready goes high.
	localparam logic [3:0]  SKID_ALLOW = 4'h4;
	localparam logic [3:0]  SKID_FULL  = 4'h8;
	// Receive source-ready must follow host not-ready within this many.
	localparam int unsigned RX_STOP_CYC = 4;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [3:0]  CNT_RST  = 4'h0;
	localparam logic [2:0]  PTR_RST  = 3'h0;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		TX_IDLE  = 3'b001,
		TX_FRAME = 3'b010,
		TX_ABORT = 3'b100
	} fis_tx_state_t;

	typedef struct packed {
		logic              last;
		logic [WORD_W-1:0] data;
	} fis_tx_word_t;

	typedef struct packed {
		logic              sof;
		logic              eof;
		logic [WORD_W-1:0] data;
	} fis_rx_word_t;

endpackage

// ---- rtl/fis_word_xing.sv ----
// Purpose: Toggle handshake carrying one word between two clock domains.
// Assumes: Both domains share one asynchronous active-low reset.
// Notes:   One word in flight; the source holds it until acknowledged.
module fis_word_xing #(
	parameter int unsigned W = 32
) (
	input  wire logic         src_clk_i,
	input  wire logic         dst_clk_i,
	input  wire logic         rst_n_i,
	input  wire logic         src_valid_i,
	output logic              src_ready_o,
	input  wire logic [W-1:0] src_data_i,
	output logic              dst_valid_o,
	input  wire logic         dst_ready_i,
	output logic [W-1:0]      dst_data_o
);

	logic         req_q, req_d, busy_q, busy_d;
	logic [W-1:0] hold_q, hold_d, data_q, data_d;
	logic [2:0]   ack_s_q, req_s_q;
	logic         ack_q, ack_d, vld_q, vld_d, done, take;

	// ------------------------------------------------------------------
	// Source side
	// ------------------------------------------------------------------
	// The ack counts only once the second and third stages agree.
	always_comb begin
		done   = busy_q && (ack_s_q[1] == ack_s_q[2]) && (ack_s_q[2] == req_q);
		req_d  = req_q;
		busy_d = busy_q & ~done;
		hold_d = hold_q;
		if (src_valid_i && !busy_q) begin
			req_d  = ~req_q;
			busy_d = 1'b1;
			hold_d = src_data_i;
		end
	end

	always_ff @(posedge src_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			req_q   <= 1'b0;
			busy_q  <= 1'b0;
			hold_q  <= '0;
			ack_s_q <= 3'h0;
		end else begin
			req_q   <= req_d;
			busy_q  <= busy_d;
			hold_q  <= hold_d;
			ack_s_q <= {ack_s_q[1:0], ack_q};
		end
	end

	assign src_ready_o = ~busy_q;

	// ------------------------------------------------------------------
	// Destination side
	// ------------------------------------------------------------------
	// The held word is stable while the request toggle is in flight.
	always_comb begin
		take   = !vld_q && (req_s_q[1] == req_s_q[2]) && (req_s_q[2] != ack_q);
		vld_d  = vld_q;
		ack_d  = ack_q;
		data_d = data_q;
		if (take) begin
			vld_d  = 1'b1;
			data_d = hold_q;
		end else if (vld_q && dst_ready_i) begin
			vld_d = 1'b0;
			ack_d = ~ack_q;
		end
	end

	always_ff @(posedge dst_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			req_s_q <= 3'h0;
			ack_q   <= 1'b0;
			vld_q   <= 1'b0;
			data_q  <= '0;
		end else begin
			req_s_q <= {req_s_q[1:0], req_q};
			ack_q   <= ack_d;
			vld_q   <= vld_d;
			data_q  <= data_d;
		end
	end

	assign dst_valid_o = vld_q;
	assign dst_data_o  = data_q;

	// Held word must not move while the destination may sample it.
	hold_stable_a: assert property (@(posedge src_clk_i) disable iff (!rst_n_i)
		busy_q && !done |=> hold_q == $past(hold_q))
		else $error("held word changed in flight");

endmodule // fis_word_xing

// ---- rtl/fis_trn_port.sv ----
// Purpose: Host transaction port moving FIS words to and from the link.
// Assumes: clk_i is the interface clock, link_clk_i the link-side clock.
// Notes:   Link-side strobes are pulses or valid/ready on link_clk_i.
module fis_trn_port (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        role_dev_i,
	output logic             role_dev_o,
	output logic             link_up_o,
	input  wire logic        tx_eof_n_i,
	input  wire logic [31:0] tx_word,
	input  wire logic        tx_src_rdy_n_i,
	output logic             tx_dst_rdy_n_o,
	input  wire logic        tx_src_abort_n_i,
	output logic             tx_dst_abort_n_o,
	output logic             rx_sof_n_o,
	output logic             rx_eof_n_o,
	output logic [31:0]      rx_word_o,
	output logic             rx_src_rdy_n_o,
	input  wire logic        rx_dst_rdy_n_i,
	output logic             rx_src_abort_n_o,
	input  wire logic        rx_dst_abort_n_i,
	input  wire logic        link_clk_i,
	input  wire logic        link_up_i,
	output logic [31:0]      link_tx_word_o,
	output logic             link_tx_last_o,
	output logic             link_tx_valid_o,
	input  wire logic        link_tx_ready_i,
	input  wire logic [31:0] link_rx_word_i,
	input  wire logic        link_rx_sof_i,
	input  wire logic        link_rx_eof_i,
	input  wire logic        link_rx_valid_i,
	output logic             link_rx_ready_o,
	input  wire logic        link_sync_rcvd_i,
	output logic             link_send_sync_o
);

	fis_pkg::fis_tx_state_t tx_st_q, tx_st_d;
	fis_pkg::fis_tx_word_t  skid_q [fis_pkg::SKID_DEPTH];
	fis_pkg::fis_tx_word_t  tx_in, tx_head, link_tx;
	fis_pkg::fis_rx_word_t  rx_x_word, link_rx;
	logic [2:0]  wr_q, wr_d, rd_q, rd_d;
	logic [3:0]  cnt_q, cnt_d;
	logic        push, pop, tx_flush, tx_x_rdy, tx_write_act, tx_abort;
	logic        sync_pend_q, sync_pend_d, sync_x_rdy, sync_evt, tdsc_d;
	logic        tdsc_q, rdsc_q, rdsc_d;
	logic [2:0]  lu_s_q, role_s_q;
	logic        link_up_q, link_up_d, role_q, role_d, role_done_q;
	logic [1:0]  fill_q, fill_d;
	logic        role_ok;
	logic        rx_x_vld, rx_x_rdy, rx_vld_q, rx_vld_d, rx_taken;
	logic        rx_sof_q, rx_sof_d, rx_eof_q, rx_eof_d, rx_abort;
	logic        rx_frm_q, rx_frm_d, rx_drop_q, rx_drop_d, rx_flush;
	logic [31:0] rx_word_q, rx_word_d;

	// ------------------------------------------------------------------
	// Pin synchronisers and role strap
	// ------------------------------------------------------------------
	// Link-up and role count only once stages two and three agree.
	// The role waits until the pipe holds pin samples, not reset zeros.
	always_comb begin
		link_up_d = link_up_q;
		role_d    = role_q;
		fill_d    = fill_q + 2'(fill_q != 2'h3);
		role_ok   = (fill_q == 2'h3) && (role_s_q[1] == role_s_q[2]);
		if (lu_s_q[1] == lu_s_q[2])
			link_up_d = lu_s_q[2];
		if (!role_done_q && role_ok)
			role_d = role_s_q[2];
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lu_s_q      <= 3'h0;
			role_s_q    <= 3'h0;
			link_up_q   <= 1'b0;
			role_q      <= 1'b0;
			role_done_q <= 1'b0;
			fill_q      <= 2'h0;
		end else begin
			lu_s_q      <= {lu_s_q[1:0], link_up_i};
			role_s_q    <= {role_s_q[1:0], role_dev_i};
			link_up_q   <= link_up_d;
			role_q      <= role_d;
			role_done_q <= role_done_q | role_ok;
			fill_q      <= fill_d;
		end
	end

	assign link_up_o  = link_up_q;
	assign role_dev_o = role_q;

	// ------------------------------------------------------------------
	// Transmit skid buffer and frame state
	// ------------------------------------------------------------------
	// Eight slots: ready drops at four held, four more still fit.
	always_comb begin
		tx_write_act = (tx_st_q == fis_pkg::TX_FRAME) || (cnt_q != 4'h0);
		tx_abort     = (tx_st_q == fis_pkg::TX_FRAME) && !tx_src_abort_n_i;
		tdsc_d       = sync_evt && tx_write_act;
		tx_flush     = tx_abort || tdsc_d;
		push = !tx_src_rdy_n_i && (cnt_q < fis_pkg::SKID_FULL)
			&& (tx_st_q != fis_pkg::TX_ABORT) && !tx_flush;
		pop  = (cnt_q != 4'h0) && tx_x_rdy && !tx_flush;
		wr_d  = tx_flush ? fis_pkg::PTR_RST : wr_q + 3'(push);
		rd_d  = tx_flush ? fis_pkg::PTR_RST : rd_q + 3'(pop);
		cnt_d = tx_flush ? fis_pkg::CNT_RST
			: cnt_q + 4'(push) - 4'(pop);
		tx_st_d = tx_st_q;
		case (tx_st_q)
			fis_pkg::TX_IDLE: begin
				if (tdsc_d)
					tx_st_d = fis_pkg::TX_IDLE;
				else if (push && tx_eof_n_i)
					tx_st_d = fis_pkg::TX_FRAME;
			end
			fis_pkg::TX_FRAME: begin
				if (tx_abort)
					tx_st_d = fis_pkg::TX_ABORT;
				else if (tdsc_d || (push && !tx_eof_n_i))
					tx_st_d = fis_pkg::TX_IDLE;
			end
			fis_pkg::TX_ABORT: begin
				if (!sync_pend_q && sync_x_rdy)
					tx_st_d = fis_pkg::TX_IDLE;
			end
			default: tx_st_d = fis_pkg::TX_IDLE;
		endcase
	end

	assign tx_in   = '{last: !tx_eof_n_i, data: tx_word};
	assign tx_head = skid_q[rd_q];

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_st_q <= fis_pkg::TX_IDLE;
			wr_q    <= fis_pkg::PTR_RST;
			rd_q    <= fis_pkg::PTR_RST;
			cnt_q   <= fis_pkg::CNT_RST;
			tdsc_q  <= 1'b0;
			skid_q  <= '{default: '0};
		end else begin
			tx_st_q <= tx_st_d;
			wr_q    <= wr_d;
			rd_q    <= rd_d;
			cnt_q   <= cnt_d;
			tdsc_q  <= tdsc_d;
			if (push)
				skid_q[wr_q] <= tx_in;
		end
	end

	assign tx_dst_rdy_n_o   = !((cnt_q < fis_pkg::SKID_ALLOW)
		&& (tx_st_q != fis_pkg::TX_ABORT));
	assign tx_dst_abort_n_o = ~tdsc_q;

	// ------------------------------------------------------------------
	// SYNC request from host aborts
	// ------------------------------------------------------------------
	// A pending request stays until the crossing takes it.
	always_comb begin
		sync_pend_d = sync_pend_q && !sync_x_rdy;
		if (tx_abort || rx_abort)
			sync_pend_d = 1'b1;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			sync_pend_q <= 1'b0;
		else
			sync_pend_q <= sync_pend_d;
	end

	// ------------------------------------------------------------------
	// Receive output stage
	// ------------------------------------------------------------------
	// Source-ready follows the host combinationally, so it drops at once.
	always_comb begin
		rx_taken  = rx_vld_q && !rx_dst_rdy_n_i;
		rx_abort  = (rx_frm_q || rx_vld_q) && !rx_dst_abort_n_i;
		rdsc_d    = sync_evt && (rx_frm_q || rx_vld_q);
		rx_flush  = rx_abort || rdsc_d;
		rx_x_rdy  = rx_drop_q || !rx_vld_q || rx_taken;
		rx_vld_d  = rx_vld_q && !rx_taken;
		rx_sof_d  = rx_sof_q;
		rx_eof_d  = rx_eof_q;
		rx_word_d = rx_word_q;
		rx_frm_d  = rx_frm_q;
		rx_drop_d = rx_drop_q;
		if (rx_taken)
			rx_frm_d = !rx_eof_q;
		if (rx_flush) begin
			rx_vld_d  = 1'b0;
			rx_frm_d  = 1'b0;
			rx_drop_d = !(rx_vld_q && rx_eof_q);
		end else if (rx_x_vld && rx_drop_q && !rx_x_word.sof) begin
			rx_drop_d = !rx_x_word.eof;
		end else if (rx_x_vld && rx_x_rdy) begin
			rx_drop_d = 1'b0;
			rx_vld_d  = 1'b1;
			rx_sof_d  = rx_x_word.sof;
			rx_eof_d  = rx_x_word.eof;
			rx_word_d = rx_x_word.data;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_vld_q  <= 1'b0;
			rx_sof_q  <= 1'b0;
			rx_eof_q  <= 1'b0;
			rx_word_q <= fis_pkg::WORD_RST;
			rx_frm_q  <= 1'b0;
			rx_drop_q <= 1'b0;
			rdsc_q    <= 1'b0;
		end else begin
			rx_vld_q  <= rx_vld_d;
			rx_sof_q  <= rx_sof_d;
			rx_eof_q  <= rx_eof_d;
			rx_word_q <= rx_word_d;
			rx_frm_q  <= rx_frm_d;
			rx_drop_q <= rx_drop_d;
			rdsc_q    <= rdsc_d;
		end
	end

	assign rx_src_rdy_n_o   = ~rx_taken;
	assign rx_sof_n_o       = ~rx_sof_q;
	assign rx_eof_n_o       = ~rx_eof_q;
	assign rx_word_o        = rx_word_q;
	assign rx_src_abort_n_o = ~rdsc_q;

	// ------------------------------------------------------------------
	// Domain crossings
	// ------------------------------------------------------------------
	// Word crossings cost several cycles each; the skid absorbs the gap.
	assign link_rx = '{sof: link_rx_sof_i, eof: link_rx_eof_i,
		data: link_rx_word_i};

	fis_word_xing #(.W(33)) u_tx_xing (
		.src_clk_i  (clk_i),
		.dst_clk_i  (link_clk_i),
		.rst_n_i    (rst_n_i),
		.src_valid_i(cnt_q != 4'h0 && !tx_flush),
		.src_ready_o(tx_x_rdy),
		.src_data_i (tx_head),
		.dst_valid_o(link_tx_valid_o),
		.dst_ready_i(link_tx_ready_i),
		.dst_data_o (link_tx)
	);

	fis_word_xing #(.W(34)) u_rx_xing (
		.src_clk_i  (link_clk_i),
		.dst_clk_i  (clk_i),
		.rst_n_i    (rst_n_i),
		.src_valid_i(link_rx_valid_i),
		.src_ready_o(link_rx_ready_o),
		.src_data_i (link_rx),
		.dst_valid_o(rx_x_vld),
		.dst_ready_i(rx_x_rdy || rx_drop_q),
		.dst_data_o (rx_x_word)
	);

	fis_word_xing #(.W(1)) u_sync_req (
		.src_clk_i  (clk_i),
		.dst_clk_i  (link_clk_i),
		.rst_n_i    (rst_n_i),
		.src_valid_i(sync_pend_q),
		.src_ready_o(sync_x_rdy),
		.src_data_i (1'b1),
		.dst_valid_o(link_send_sync_o),
		.dst_ready_i(1'b1),
		.dst_data_o ()
	);

	fis_word_xing #(.W(1)) u_sync_rcvd (
		.src_clk_i  (link_clk_i),
		.dst_clk_i  (clk_i),
		.rst_n_i    (rst_n_i),
		.src_valid_i(link_sync_rcvd_i),
		.src_ready_o(),
		.src_data_i (1'b1),
		.dst_valid_o(sync_evt),
		.dst_ready_i(1'b1),
		.dst_data_o ()
	);

	assign link_tx_word_o = link_tx.data;
	assign link_tx_last_o = link_tx.last;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	link_up_follow_a: assert property (
		lu_s_q[1] == lu_s_q[2] |=> link_up_o == $past(lu_s_q[2]))
		else $error("link-up did not follow the link");
	tx_ready_room_a: assert property (
		cnt_q >= fis_pkg::SKID_ALLOW |-> tx_dst_rdy_n_o)
		else $error("ready shown with no room");
	skid_accept_a: assert property (
		!tx_src_rdy_n_i && cnt_q < fis_pkg::SKID_FULL && !tx_flush
		&& tx_st_q != fis_pkg::TX_ABORT |=> cnt_q == $past(cnt_q)
		+ 4'h1 - 4'($past(pop)))
		else $error("allowance word lost");
	tx_abort_sync_a: assert property (
		tx_abort |=> sync_pend_q ##0 tx_st_q == fis_pkg::TX_ABORT)
		else $error("transmit abort sent no SYNC");
	tx_dsc_pulse_a: assert property (
		$fell(tx_dst_abort_n_o) |=> tx_dst_abort_n_o)
		else $error("transmit abort pulse too long");
	rx_sof_start_a: assert property (
		!rx_src_rdy_n_o && !rx_sof_n_o |-> !rx_frm_q)
		else $error("start of frame inside a frame");
	rx_valid_gate_a: assert property (
		!rx_src_rdy_n_o |-> rx_vld_q && !rx_dst_rdy_n_i)
		else $error("receive ready without a word");
	rx_stop_a: assert property (
		$rose(rx_dst_rdy_n_i) |-> ##[0:4] rx_src_rdy_n_o)
		else $error("receive ready not withdrawn");
	rx_dsc_pulse_a: assert property (
		$fell(rx_src_abort_n_o) |=> rx_src_abort_n_o)
		else $error("receive abort pulse too long");
	rx_abort_sync_a: assert property (
		rx_abort |=> sync_pend_q && !rx_vld_q)
		else $error("receive abort sent no SYNC");
	push_gate_a: assert property (
		push |-> !tx_src_rdy_n_i)
		else $error("word taken without source-ready");

	tx_frame_c: cover property (push && !tx_eof_n_i
		&& tx_st_q == fis_pkg::TX_FRAME);
	tx_abort_c: cover property (tx_st_q == fis_pkg::TX_ABORT
		##1 tx_st_q == fis_pkg::TX_IDLE);
	rx_frame_c: cover property (rx_taken && rx_eof_q);
	sync_rcvd_c: cover property (!tx_dst_abort_n_o || !rx_src_abort_n_o);

endmodule // fis_trn_port

// ---- verif/fis_link_model.sv ----
// Purpose: Link-side partner model of the FIS transaction port.
// Assumes: The link clock runs free; a SYNC flag lasts one link cycle.
// Notes:   Receive lines show the inverse of the last word once released.
module fis_link_model (
	input  wire logic        link_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [31:0] tx_word_i,
	input  wire logic        tx_last_i,
	input  wire logic        tx_valid_i,
	output logic             tx_ready_o,
	output logic [31:0]      rx_word_o,
	output logic             rx_sof_o,
	output logic             rx_eof_o,
	output logic             rx_valid_o,
	input  wire logic        rx_ready_i,
	output logic             sync_o,
	input  wire logic        send_sync_i,
	output logic             up_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [32:0] got_q[$];
	int          sync_seen;
	int          up_cnt;
	logic        stall;

	initial begin
		{rx_word_o, rx_sof_o, rx_eof_o, rx_valid_o} = '0;
		{sync_o, up_o, tx_ready_o, stall} = '0;
		sync_seen = 0;
	end

	// Collect words and count SYNC requests; stall models a slow link.
	always @(posedge link_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			up_cnt = 0;
			up_o <= 1'b0;
		end else begin
			if (up_cnt < 8) up_cnt++;
			else up_o <= 1'b1;
			tx_ready_o <= !stall;
			if (tx_valid_i && tx_ready_o) got_q.push_back({tx_last_i, tx_word_i});
			if (send_sync_i) sync_seen++;
		end
	end

	// Offer one word and hold it until the port takes it.
	task automatic send(input logic [31:0] w, input logic s, input logic e);
		@(posedge link_clk_i);
		rx_valid_o <= 1'b1;
		rx_word_o <= w;
		rx_sof_o <= s;
		rx_eof_o <= e;
		for (int i = 0; i < 200; i++) begin
			@(posedge link_clk_i);
			if (rx_ready_i) break;
		end
		rx_valid_o <= 1'b0;
		rx_word_o <= ~w;
		rx_sof_o <= ~s;
		rx_eof_o <= ~e;
	endtask

	// One-cycle flag that a SYNC primitive arrived.
	task automatic pulse_sync;
		@(posedge link_clk_i);
		sync_o <= 1'b1;
		@(posedge link_clk_i);
		sync_o <= 1'b0;
	endtask
endmodule // fis_link_model

// ---- verif/tb_top.sv ----
// Purpose: Self-checking bench of the FIS transaction port.
// Assumes: Host side driven here, link side by the partner model.
// Notes:   Bounded waits only; a hang ends through the watchdog.
`define CHK(nm, e, g) begin n_compared++; if ((e) !== (g)) begin fails++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
`define WT(c) for (int w_ = 0; w_ < 80 && !(c); w_++) @(posedge clk_i)
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i, rst_n_i, role_dev_i, tx_eof_n_i, tx_src_rdy_n_i;
	logic        tx_src_abort_n_i, rx_dst_rdy_n_i, rx_dst_abort_n_i;
	logic        link_clk_i, role_dev_o, link_up_o, tx_dst_rdy_n_o;
	logic        tx_dst_abort_n_o, rx_sof_n_o, rx_eof_n_o, rx_src_rdy_n_o;
	logic        rx_src_abort_n_o, link_up_i, link_tx_last_o;
	logic        link_tx_valid_o, link_tx_ready_i, link_rx_sof_i;
	logic        link_rx_eof_i, link_rx_valid_i, link_rx_ready_o;
	logic        link_sync_rcvd_i, link_send_sync_o, hi;
	logic [31:0] tx_word, rx_word_o, link_tx_word_o, link_rx_word_i;
	int          fails, n_compared, n, s;

	fis_trn_port dut_u (.clk_i, .rst_n_i, .role_dev_i, .role_dev_o,
		.link_up_o, .tx_eof_n_i, .tx_word, .tx_src_rdy_n_i, .tx_dst_rdy_n_o,
		.tx_src_abort_n_i, .tx_dst_abort_n_o, .rx_sof_n_o, .rx_eof_n_o,
		.rx_word_o, .rx_src_rdy_n_o, .rx_dst_rdy_n_i, .rx_src_abort_n_o,
		.rx_dst_abort_n_i, .link_clk_i, .link_up_i, .link_tx_word_o,
		.link_tx_last_o, .link_tx_valid_o, .link_tx_ready_i, .link_rx_word_i,
		.link_rx_sof_i, .link_rx_eof_i, .link_rx_valid_i, .link_rx_ready_o,
		.link_sync_rcvd_i, .link_send_sync_o);

	fis_link_model link_u (.link_clk_i, .rst_n_i, .tx_word_i(link_tx_word_o),
		.tx_last_i(link_tx_last_o), .tx_valid_i(link_tx_valid_o),
		.tx_ready_o(link_tx_ready_i), .rx_word_o(link_rx_word_i),
		.rx_sof_o(link_rx_sof_i), .rx_eof_o(link_rx_eof_i),
		.rx_valid_o(link_rx_valid_i), .rx_ready_i(link_rx_ready_o),
		.sync_o(link_sync_rcvd_i), .send_sync_i(link_send_sync_o),
		.up_o(link_up_i));

	// Clocks: 25 ns host side, 15 ns link side, phases unrelated.
	always #12.5 clk_i = ~clk_i;
	always #7.5 link_clk_i = ~link_clk_i;

	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic push(input logic [31:0] w, input logic e);
		@(posedge clk_i);
		tx_src_rdy_n_i <= 1'b0;
		tx_word <= w;
		tx_eof_n_i <= !e;
	endtask

	task automatic tx_idle;
		@(posedge clk_i);
		tx_src_rdy_n_i <= 1'b1;
		tx_eof_n_i <= 1'b1;
		tx_word <= ~tx_word;
	endtask

	task automatic tx_expect(input logic [31:0] w, input logic e);
		logic [32:0] g;
		`WT(link_u.got_q.size() > 0);
		g = link_u.got_q.size() ? link_u.got_q.pop_front() : 33'bx;
		`CHK("tx word", {e, w}, g);
	endtask

	task automatic t_up;
		`CHK("link up early", 1'b0, link_up_o);
		`WT(link_up_o === 1'b1);
		`CHK("link up", 1'b1, link_up_o);
		`CHK("role", 1'b1, role_dev_o);
		$display("t_up done");
	endtask

	task automatic t_tx_frame;
		`WT(tx_dst_rdy_n_o === 1'b0);
		`CHK("tx ready", 1'b0, tx_dst_rdy_n_o);
		for (int i = 1; i <= 3; i++) push(32'h1111_0000 + i, i == 3);
		tx_idle();
		for (int i = 1; i <= 3; i++) tx_expect(32'h1111_0000 + i, i == 3);
		$display("t_tx_frame done");
	endtask

	task automatic t_tx_skid;
		link_u.stall <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			hi = tx_dst_rdy_n_o;
			tx_src_rdy_n_i <= 1'b0;
			tx_word <= 32'h2222_0000 + n;
			tx_eof_n_i <= 1'b1;
			n++;
		end while (hi !== 1'b1 && n < 30);
		`CHK("tx not ready", 1'b1, hi);
		push(32'h2222_0000 + n, 1'b0);
		push(32'h2222_0001 + n, 1'b1);
		n += 2;
		tx_idle();
		link_u.stall <= 1'b0;
		for (int i = 0; i < n; i++) tx_expect(32'h2222_0000 + i, i == n - 1);
		$display("t_tx_skid done");
	endtask

	task automatic t_tx_abort;
		`WT(tx_dst_rdy_n_o === 1'b0);
		s = link_u.sync_seen;
		push(32'h3333_0001, 1'b0);
		push(32'h3333_0002, 1'b0);
		@(posedge clk_i);
		tx_src_rdy_n_i <= 1'b1;
		tx_src_abort_n_i <= 1'b0;
		@(posedge clk_i);
		tx_src_abort_n_i <= 1'b1;
		@(posedge clk_i);
		`CHK("abort hold", 1'b1, tx_dst_rdy_n_o);
		`WT(tx_dst_rdy_n_o === 1'b0);
		`CHK("abort ready", 1'b0, tx_dst_rdy_n_o);
		repeat (10) @(posedge clk_i);
		`CHK("wr sync", s + 1, link_u.sync_seen);
		link_u.got_q.delete();
		$display("t_tx_abort done");
	endtask

	task automatic t_tx_sync;
		link_u.stall <= 1'b1;
		push(32'h4444_0001, 1'b0);
		tx_idle();
		link_u.pulse_sync();
		`WT(tx_dst_abort_n_o === 1'b0);
		`CHK("wr abort", 1'b0, tx_dst_abort_n_o);
		@(posedge clk_i);
		`CHK("wr abort len", 1'b1, tx_dst_abort_n_o);
		link_u.stall <= 1'b0;
		repeat (20) @(posedge clk_i);
		link_u.got_q.delete();
		$display("t_tx_sync done");
	endtask

	task automatic t_rx;
		@(posedge clk_i);
		rx_dst_rdy_n_i <= 1'b0;
		fork
			begin
				link_u.send(32'h5555_0001, 1'b1, 1'b0);
				link_u.send(32'h5555_0002, 1'b0, 1'b0);
				link_u.send(32'h5555_0003, 1'b0, 1'b1);
			end
		join_none
		for (int i = 1; i <= 3; i++) begin
			`WT(rx_src_rdy_n_o === 1'b0);
			`CHK("rx word", 32'h5555_0000 + i, rx_word_o);
			`CHK("rx sof", i != 1, rx_sof_n_o);
			`CHK("rx eof", i != 3, rx_eof_n_o);
			if (i == 1) begin
				rx_dst_rdy_n_i <= 1'b1;
				repeat (4) @(posedge clk_i);
				n = 0;
				repeat (20) begin
					@(posedge clk_i);
					n += (rx_src_rdy_n_o === 1'b0);
				end
				`CHK("rx stopped", 0, n);
				rx_dst_rdy_n_i <= 1'b0;
			end
			@(posedge clk_i);
		end
		$display("t_rx done");
	endtask

	task automatic t_rx_abort;
		@(posedge clk_i);
		rx_dst_rdy_n_i <= 1'b1;
		s = link_u.sync_seen;
		fork
			link_u.send(32'h6666_0001, 1'b1, 1'b0);
		join_none
		repeat (20) @(posedge clk_i);
		rx_dst_abort_n_i <= 1'b0;
		@(posedge clk_i);
		rx_dst_abort_n_i <= 1'b1;
		repeat (30) @(posedge clk_i);
		`CHK("rd sync", s + 1, link_u.sync_seen);
		$display("t_rx_abort done");
	endtask

	task automatic t_rx_sync;
		fork
			link_u.send(32'h7777_0001, 1'b1, 1'b0);
		join_none
		repeat (20) @(posedge clk_i);
		link_u.pulse_sync();
		`WT(rx_src_abort_n_o === 1'b0);
		`CHK("rd abort", 1'b0, rx_src_abort_n_o);
		@(posedge clk_i);
		`CHK("rd abort len", 1'b1, rx_src_abort_n_o);
		rx_dst_rdy_n_i <= 1'b0;
		n = 0;
		repeat (20) begin
			@(posedge clk_i);
			n += (rx_src_rdy_n_o === 1'b0);
		end
		`CHK("rx dropped", 0, n);
		$display("t_rx_sync done");
	endtask

	// Main sequence; reset spans 10 host cycles, over 4 link periods.
	initial begin
		{clk_i, link_clk_i, rst_n_i} = '0;
		{tx_src_rdy_n_i, tx_eof_n_i, tx_src_abort_n_i} = '1;
		{rx_dst_rdy_n_i, rx_dst_abort_n_i} = '1;
		role_dev_i = 1'b1;
		tx_word = 32'h0;
		fails = 0;
		n_compared = 0;
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		t_up();
		t_tx_frame();
		t_tx_skid();
		t_tx_abort();
		t_tx_sync();
		t_rx();
		t_rx_abort();
		t_rx_sync();
		stop_test();
	end

	// Watchdog: the tests need a few thousand cycles at most.
	initial begin
		#300us;
		fails++;
		stop_test();
	end
endmodule // tb_top
